// ### tcc_cfg.svh
// register map, field positions and reset values of the timer control core
`ifndef TCC_CFG_SVH
`define TCC_CFG_SVH

`define TCC_ADDR_W 5
`define TCC_OFS_CLK 5'h00
`define TCC_OFS_CTL 5'h04
`define TCC_OFS_MAX 5'h08
`define TCC_OFS_CNT 5'h0C
`define TCC_OFS_STS 5'h10

`define TCC_CLK_SRC_LSB 0
`define TCC_CLK_SRC_MSB 2
`define TCC_CLK_DIV_LSB 4
`define TCC_CLK_DIV_MSB 7
`define TCC_CLK_DBG_BIT 8

`define TCC_CTL_EN_BIT 0
`define TCC_CTL_PRESET_BIT 1
`define TCC_CTL_RUN_BIT 2
`define TCC_CTL_ONESHOT_BIT 3
`define TCC_CTL_MODE_LSB 4
`define TCC_CTL_MODE_MSB 5
`define TCC_CTL_MAX_LOAD_PENDING_BIT 8

`define TCC_STS_ACTIVE_BIT 0
`define TCC_STS_UP_BIT 1

`define TCC_MAX_RESET 16'hFFFF
`define TCC_CNT_RESET 16'h0000
`define TCC_SRC_RESET 3'h0
`define TCC_DIV_RESET 4'h0
`define TCC_DIV_BYPASS 4'hF
`define TCC_DIV_LOW_LIMIT 4'h8
`define TCC_PRESCALE_W 15

`endif

// ### tcc_clk_src.sv
// source selection, edge detection and power-of-two prescaler
`timescale 1ns/10ps
`default_nettype none
`include "tcc_cfg.svh"
module tcc_clk_src (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [5:0] src_sync,
	input wire tcc_pkg::tcc_src_t src_sel,
	input wire logic [3:0] div_sel,
	input wire logic gate_on,
	output logic count_tick
);

	logic [5:0] src_prev;
	logic [5:0] next_src_prev;
	logic [`TCC_PRESCALE_W-1:0] pre;
	logic [`TCC_PRESCALE_W-1:0] next_pre;
	logic tick;
	logic next_tick;
	logic [5:0] rise;
	logic [5:0] fall;
	logic src_edge;
	logic [3:0] eff_div;
	logic [`TCC_PRESCALE_W-1:0] mask;

	always_comb begin
		rise = src_sync & ~src_prev;
		fall = ~src_sync & src_prev;
		case (src_sel) // [R2]
			tcc_pkg::TCC_SRC_IRC: src_edge = rise[0];
			tcc_pkg::TCC_SRC_LOW: src_edge = rise[1];
			tcc_pkg::TCC_SRC_HIGH: src_edge = rise[2];
			tcc_pkg::TCC_SRC_EXTOSC: src_edge = rise[3];
			tcc_pkg::TCC_SRC_PIN0: src_edge = rise[4];
			tcc_pkg::TCC_SRC_PIN1: src_edge = rise[5];
			tcc_pkg::TCC_SRC_PIN0_INV: src_edge = fall[4];
			tcc_pkg::TCC_SRC_PIN1_INV: src_edge = fall[5];
			default: src_edge = 1'b0;
		endcase
		// only the two fast oscillators and the slow one are divided
		case (src_sel) // [R3]
			tcc_pkg::TCC_SRC_IRC,
			tcc_pkg::TCC_SRC_HIGH: eff_div = div_sel;
			tcc_pkg::TCC_SRC_LOW: begin
				if (div_sel > `TCC_DIV_LOW_LIMIT) begin
					eff_div = 4'h0;
				end else begin
					eff_div = div_sel;
				end
			end
			default: eff_div = 4'h0;
		endcase
		mask = `TCC_PRESCALE_W'((16'h0001 << eff_div) - 16'h0001);
		next_src_prev = src_sync;
		next_pre = pre;
		next_tick = 1'b0;
		if (!gate_on) begin // [R1] [R14]
			next_pre = '0;
		end else if (src_edge) begin
			if ((pre & mask) == mask) begin
				next_pre = '0;
				next_tick = 1'b1;
			end else begin
				next_pre = pre + `TCC_PRESCALE_W'(1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			src_prev <= 6'h00;
			pre <= '0;
			tick <= 1'b0;
		end else begin
			src_prev <= next_src_prev;
			pre <= next_pre;
			tick <= next_tick;
		end
	end

	assign count_tick = tick;

endmodule : tcc_clk_src
`default_nettype wire

// ### tcc_pkg.sv
// types shared by the timer control core
package tcc_pkg;

	typedef enum logic [1:0] {
		TCC_MODE_UP = 2'h0,
		TCC_MODE_DOWN = 2'h1,
		TCC_MODE_UPDOWN = 2'h2,
		TCC_MODE_RSVD = 2'h3
	} tcc_mode_t;

	typedef enum logic [2:0] {
		TCC_SRC_IRC = 3'h0,
		TCC_SRC_LOW = 3'h1,
		TCC_SRC_HIGH = 3'h2,
		TCC_SRC_EXTOSC = 3'h3,
		TCC_SRC_PIN0 = 3'h4,
		TCC_SRC_PIN1 = 3'h5,
		TCC_SRC_PIN0_INV = 3'h6,
		TCC_SRC_PIN1_INV = 3'h7
	} tcc_src_t;

endpackage : tcc_pkg

// ### tcc_sync.sv
// two-flop synchroniser, one per bit
`timescale 1ns/10ps
`default_nettype none
module tcc_sync #(
	parameter int WIDTH = 6
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	if (WIDTH < 1) begin : g_bad_width
		$error("tcc_sync needs at least one bit");
	end

	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		logic meta;
		logic stable;
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				meta <= 1'b0;
				stable <= 1'b0;
			end else begin
				meta <= async_in[i];
				stable <= meta;
			end
		end
		assign sync_out[i] = stable;
	end

endmodule : tcc_sync
`default_nettype wire

// ### tcc_top.sv
// timer channel control core: registers, clock gate and 16-bit counter
//
// Overview of operation
// (R1) debug_clock_keep 1 keeps the count clock in debug mode; 0 withholds it.
// (R2) clock_source_select picks one of four oscillators or two pins, optionally inverted.
// (R3) divider 2^n for internal and high-speed sources; low-speed up to 1/256.
// (R4) sources absent from this device can never be selected.
// (R5) max_load_pending reads 1 while a new MAX is being loaded.
// (R6) count_direction_mode: up, down, up/down; value 3 reserved.
// (R7) single_pass_select 1 runs once, 0 repeats.
// (R8) writing run 1 starts counting if enable is or becomes 1.
// (R9) writing run 0 while running halts counting.
// (R10) one-shot end at MAX or zero clears run by hardware.
// (R11) reinitialise in up or up/down mode clears counter to zero.
// (R12) reinitialise in down mode loads counter with MAX.
// (R13) reinitialise bit reads 1 while reinitialisation is in progress.
// (R14) channel_enable starts and stops the channel clock supply.
// (R15) reinitialise and start work only with channel_enable at 1.
// (R16) 16-bit MAX register, read/write, resets to all ones.
// (R17) software keeps MAX steady during one-shot counting.
// (R18) software sets enable before writing MAX and holds it meanwhile.
// (R19) software never programs MAX to zero.
// (R20) read-only counter value register resets to zero.
// (R21) counter_active reads 1 while counting, 0 when idle.
// (R22) direction status reads 1 counting up, 0 down; resets to 1.
// (R23) reserved bits of clock and counter control read zero.
`timescale 1ns/10ps
`default_nettype none
`include "tcc_cfg.svh"
module tcc_top #(
	parameter logic [7:0] SRC_PRESENT = 8'hFF
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [`TCC_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic internal_rc_osc,
	input wire logic low_speed_osc,
	input wire logic high_speed_osc,
	input wire logic external_osc_input,
	input wire logic ext_clock_pin_0,
	input wire logic ext_clock_pin_1,
	input wire logic debug_mode,
	output logic count_clock_tick,
	output logic counter_at_max,
	output logic counter_at_zero
);

	// reset source must exist, otherwise clock_source_select resets to an absent source
	if (SRC_PRESENT[0] != 1'b1) begin : g_bad_src
		$error("tcc_top: clock source 0 must be present");
	end
	// bus handshake state
	logic ack;
	logic next_ack;
	logic [31:0] rdata;
	logic [31:0] next_rdata;
	// control registers
	logic debug_clock_keep;
	logic next_debug_clock_keep;
	logic [3:0] clock_divide_select;
	logic [3:0] next_clock_divide_select;
	tcc_pkg::tcc_src_t clock_source_select;
	tcc_pkg::tcc_src_t next_clock_source_select;
	tcc_pkg::tcc_mode_t count_direction_mode;
	tcc_pkg::tcc_mode_t next_count_direction_mode;
	logic single_pass_select;
	logic next_single_pass_select;
	logic channel_enable;
	logic next_channel_enable;
	logic run;
	logic next_run;
	logic preset_pending;
	logic next_preset_pending;
	logic [15:0] max_value;
	logic [15:0] next_max_value;
	logic max_load_pending;
	logic next_max_load_pending;
	// counter state
	logic [15:0] max_active;
	logic [15:0] next_max_active;
	logic [15:0] counter_value;
	logic [15:0] next_counter_value;
	logic count_up;
	logic next_count_up;
	logic hit_max;
	logic next_hit_max;
	logic hit_zero;
	logic next_hit_zero;
	// decode and helpers
	logic wr_take;
	logic rd_take;
	logic wr_clk;
	logic wr_ctl;
	logic wr_max;
	logic [15:0] wdata;
	logic en_after;
	logic [5:0] src_sync;
	logic gate_on;
	logic tick;
	logic [2:0] new_src;
	logic [1:0] new_mode;
	logic [15:0] clk_reg;
	logic [15:0] ctl_reg;
	logic [15:0] sts_reg;
	logic hw_stop;
	logic [15:0] cnt_inc;
	logic [15:0] cnt_dec;

	tcc_sync #(
		.WIDTH(6)
	) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.async_in({ext_clock_pin_1, ext_clock_pin_0, external_osc_input,
			high_speed_osc, low_speed_osc, internal_rc_osc}),
		.sync_out(src_sync)
	);
	// count clock only flows while enabled and, in debug, when allowed
	assign gate_on = channel_enable & (~debug_mode | debug_clock_keep); // [R1] [R14]

	tcc_clk_src u_clk_src (
		.clk(clk),
		.rst_n(rst_n),
		.src_sync(src_sync),
		.src_sel(clock_source_select),
		.div_sel(clock_divide_select),
		.gate_on(gate_on),
		.count_tick(tick)
	);
	// one wait state: a write is taken on the edge where ack is high, a read on the edge where ack is low
	assign avs_waitrequest = (avs_read | avs_write) & ~ack;
	assign wr_take = avs_write & ack;
	assign rd_take = avs_read & ~ack;
	assign wdata = avs_writedata[15:0];
	assign wr_clk = wr_take && (avs_address == `TCC_OFS_CLK);
	assign wr_ctl = wr_take && (avs_address == `TCC_OFS_CTL);
	assign wr_max = wr_take && (avs_address == `TCC_OFS_MAX);
	assign new_src = wdata[`TCC_CLK_SRC_MSB:`TCC_CLK_SRC_LSB];
	assign new_mode = wdata[`TCC_CTL_MODE_MSB:`TCC_CTL_MODE_LSB];
	assign en_after = (wr_ctl && avs_byteenable[0]) ?
		wdata[`TCC_CTL_EN_BIT] : channel_enable;
	// read images; unlisted bits stay zero
	always_comb begin
		clk_reg = 16'h0000; // [R23]
		clk_reg[`TCC_CLK_SRC_MSB:`TCC_CLK_SRC_LSB] = clock_source_select;
		clk_reg[`TCC_CLK_DIV_MSB:`TCC_CLK_DIV_LSB] = clock_divide_select;
		clk_reg[`TCC_CLK_DBG_BIT] = debug_clock_keep;
		ctl_reg = 16'h0000; // [R23]
		ctl_reg[`TCC_CTL_EN_BIT] = channel_enable;
		ctl_reg[`TCC_CTL_PRESET_BIT] = preset_pending; // [R13]
		ctl_reg[`TCC_CTL_RUN_BIT] = run; // [R8]
		ctl_reg[`TCC_CTL_ONESHOT_BIT] = single_pass_select;
		ctl_reg[`TCC_CTL_MODE_MSB:`TCC_CTL_MODE_LSB] = count_direction_mode;
		ctl_reg[`TCC_CTL_MAX_LOAD_PENDING_BIT] = max_load_pending; // [R5]
		sts_reg = 16'h0000;
		sts_reg[`TCC_STS_ACTIVE_BIT] = run; // [R21]
		sts_reg[`TCC_STS_UP_BIT] = count_up; // [R22]
	end
	// bus answer
	always_comb begin
		next_ack = (avs_read | avs_write) & ~ack;
		next_rdata = rdata;
		if (rd_take) begin
			case (avs_address)
				`TCC_OFS_CLK: next_rdata = {16'h0000, clk_reg};
				`TCC_OFS_CTL: next_rdata = {16'h0000, ctl_reg};
				`TCC_OFS_MAX: next_rdata = {16'h0000, max_value}; // [R16]
				`TCC_OFS_CNT: next_rdata = {16'h0000, counter_value}; // [R20]
				`TCC_OFS_STS: next_rdata = {16'h0000, sts_reg};
				default: next_rdata = 32'h00000000;
			endcase
		end
	end
	// clock control register
	always_comb begin
		next_debug_clock_keep = debug_clock_keep;
		next_clock_divide_select = clock_divide_select;
		next_clock_source_select = clock_source_select;
		if (wr_clk && avs_byteenable[0]) begin
			next_clock_divide_select =
				wdata[`TCC_CLK_DIV_MSB:`TCC_CLK_DIV_LSB];
			// an absent source is never taken
			if (SRC_PRESENT[new_src]) begin // [R4]
				next_clock_source_select = tcc_pkg::tcc_src_t'(new_src); // [R2]
			end
		end
		if (wr_clk && avs_byteenable[1]) begin
			next_debug_clock_keep = wdata[`TCC_CLK_DBG_BIT]; // [R1]
		end
	end
	// counter control register and max value loading
	always_comb begin
		next_channel_enable = channel_enable;
		next_single_pass_select = single_pass_select;
		next_count_direction_mode = count_direction_mode;
		next_preset_pending = 1'b0;
		next_run = run & ~hw_stop; // [R10]
		next_max_value = max_value;
		next_max_load_pending = max_load_pending;
		next_max_active = max_active;
		// the count clock hands a pending MAX to the counter
		if (max_load_pending && tick) begin // [R5]
			next_max_active = max_value;
			next_max_load_pending = 1'b0;
		end
		// writes are refused while a previous MAX is still loading
		if (wr_max && !max_load_pending) begin // [R5] [R16]
			if (avs_byteenable[0]) begin
				next_max_value[7:0] = wdata[7:0];
			end
			if (avs_byteenable[1]) begin
				next_max_value[15:8] = wdata[15:8];
			end
			next_max_load_pending = avs_byteenable[0] | avs_byteenable[1];
		end
		if (wr_ctl && avs_byteenable[0]) begin
			next_channel_enable = wdata[`TCC_CTL_EN_BIT]; // [R14]
			next_single_pass_select = wdata[`TCC_CTL_ONESHOT_BIT]; // [R7]
			if (new_mode != tcc_pkg::TCC_MODE_RSVD) begin // [R6]
				next_count_direction_mode = tcc_pkg::tcc_mode_t'(new_mode);
			end
			// start wins over a same-cycle hardware stop
			if (wdata[`TCC_CTL_RUN_BIT] && en_after) begin // [R8] [R15]
				next_run = 1'b1;
			end else if (!wdata[`TCC_CTL_RUN_BIT]) begin
				next_run = 1'b0; // [R9]
			end
			if (wdata[`TCC_CTL_PRESET_BIT] && en_after) begin // [R15]
				next_preset_pending = 1'b1; // [R13]
			end
		end
	end
	// neighbouring count values in either direction
	assign cnt_inc = counter_value + 16'h0001;
	assign cnt_dec = counter_value - 16'h0001;

	// counter datapath
	always_comb begin
		next_counter_value = counter_value;
		next_count_up = count_up;
		next_hit_max = 1'b0;
		next_hit_zero = 1'b0;
		hw_stop = 1'b0;
		if (preset_pending) begin
			if (count_direction_mode == tcc_pkg::TCC_MODE_DOWN) begin
				next_counter_value = max_active; // [R12]
				next_count_up = 1'b0;
			end else begin
				next_counter_value = 16'h0000; // [R11]
				next_count_up = 1'b1;
			end
		end else if (tick && run) begin
			case (count_direction_mode) // [R6]
				tcc_pkg::TCC_MODE_UP: begin
					next_count_up = 1'b1;
					if (counter_value >= max_active) begin
						next_counter_value = 16'h0000;
						next_hit_zero = 1'b1;
					end else begin
						next_counter_value = cnt_inc;
						if (cnt_inc == max_active) begin
							next_hit_max = 1'b1;
							hw_stop = single_pass_select; // [R7] [R10]
						end
					end
				end
				tcc_pkg::TCC_MODE_DOWN: begin
					next_count_up = 1'b0;
					if (counter_value == 16'h0000) begin
						next_counter_value = max_active;
						next_hit_max = 1'b1;
					end else begin
						next_counter_value = cnt_dec;
						if (cnt_dec == 16'h0000) begin
							next_hit_zero = 1'b1;
							hw_stop = single_pass_select; // [R7] [R10]
						end
					end
				end
				tcc_pkg::TCC_MODE_UPDOWN: begin
					if (count_up) begin
						if (counter_value >= max_active) begin
							next_counter_value = cnt_dec;
							next_count_up = 1'b0;
						end else begin
							next_counter_value = cnt_inc;
							if (cnt_inc == max_active) begin
								next_hit_max = 1'b1;
								next_count_up = 1'b0;
							end
						end
					end else begin
						if (counter_value == 16'h0000) begin
							next_counter_value = cnt_inc;
							next_count_up = 1'b1;
						end else begin
							next_counter_value = cnt_dec;
							if (cnt_dec == 16'h0000) begin
								next_hit_zero = 1'b1;
								next_count_up = 1'b1;
								hw_stop = single_pass_select; // [R10]
							end
						end
					end
				end
				default: next_counter_value = counter_value;
			endcase
		end
		// outside up/down counting the status follows the mode
		if (!preset_pending
			&& count_direction_mode != tcc_pkg::TCC_MODE_UPDOWN) begin
			next_count_up = (count_direction_mode != tcc_pkg::TCC_MODE_DOWN); // [R22]
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ack <= 1'b0;
			rdata <= 32'h00000000;
			debug_clock_keep <= 1'b0;
			clock_divide_select <= `TCC_DIV_RESET;
			clock_source_select <= tcc_pkg::tcc_src_t'(`TCC_SRC_RESET);
			count_direction_mode <= tcc_pkg::TCC_MODE_UP;
			single_pass_select <= 1'b0;
			channel_enable <= 1'b0;
			run <= 1'b0;
			preset_pending <= 1'b0;
			max_value <= `TCC_MAX_RESET; // [R16]
			max_load_pending <= 1'b0;
			max_active <= `TCC_MAX_RESET;
			counter_value <= `TCC_CNT_RESET; // [R20]
			count_up <= 1'b1; // [R22]
			hit_max <= 1'b0;
			hit_zero <= 1'b0;
		end else begin
			ack <= next_ack;
			rdata <= next_rdata;
			debug_clock_keep <= next_debug_clock_keep;
			clock_divide_select <= next_clock_divide_select;
			clock_source_select <= next_clock_source_select;
			count_direction_mode <= next_count_direction_mode;
			single_pass_select <= next_single_pass_select;
			channel_enable <= next_channel_enable;
			run <= next_run;
			preset_pending <= next_preset_pending;
			max_value <= next_max_value;
			max_load_pending <= next_max_load_pending;
			max_active <= next_max_active;
			counter_value <= next_counter_value;
			count_up <= next_count_up;
			hit_max <= next_hit_max;
			hit_zero <= next_hit_zero;
		end
	end

	assign avs_readdata = rdata;
	assign count_clock_tick = tick;
	assign counter_at_max = hit_max;
	assign counter_at_zero = hit_zero;

endmodule : tcc_top
`default_nettype wire

// ### tcc_top_assertions.sv
// port assertions for the timer control core and their bind
`timescale 1ns/10ps
`default_nettype none
`include "tcc_cfg.svh"
module tcc_top_checker (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [`TCC_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic debug_mode,
	input wire logic count_clock_tick,
	input wire logic counter_at_max,
	input wire logic counter_at_zero
);
	logic keep_q;
	logic next_keep_q;
	logic en_q;
	logic next_en_q;
	// shadow copies of the gate bits, taken from accepted writes
	always_comb begin
		next_keep_q = keep_q;
		next_en_q = en_q;
		if (avs_write && !avs_waitrequest) begin
			if (avs_address == `TCC_OFS_CLK && avs_byteenable[1])
				next_keep_q = avs_writedata[`TCC_CLK_DBG_BIT];
			if (avs_address == `TCC_OFS_CTL && avs_byteenable[0])
				next_en_q = avs_writedata[`TCC_CTL_EN_BIT];
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			keep_q <= 1'b0;
			en_q <= 1'b0;
		end else begin
			keep_q <= next_keep_q;
			en_q <= next_en_q;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wait_first_a: assert property ((avs_read || avs_write) && !avs_waitrequest
		##1 (avs_read || avs_write) |-> avs_waitrequest)
		else $error("new request answered without a wait state");
	one_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest || !(avs_read || avs_write))
		else $error("request held more than one wait state");
	idle_wait_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("waitrequest high without a request");
	upper_zero_a: assert property (avs_readdata[31:16] == 16'h0000)
		else $error("upper read data not zero");
	rdata_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
		else $error("read data changed without a read");
	tick_single_a: assert property (count_clock_tick |=> !count_clock_tick)
		else $error("count tick longer than one cycle");
	reset_quiet_a: assert property ($rose(rst_n) |-> !count_clock_tick &&
		!counter_at_max && !counter_at_zero && avs_readdata == 32'h00000000)
		else $error("outputs not cleared by reset");
	debug_gate_a: assert property ((debug_mode && !keep_q)[*6]
		|-> !count_clock_tick)
		else $error("count tick in debug mode without keep");
	enable_gate_a: assert property ((!en_q)[*6] |-> !count_clock_tick &&
		!counter_at_max && !counter_at_zero)
		else $error("counting while channel disabled");
	max_zero_excl_a: assert property (counter_at_max |-> !counter_at_zero)
		else $error("max and zero pulses together");
endmodule : tcc_top_checker
bind tcc_top tcc_top_checker u_chk (
	.clk(clk),
	.rst_n(rst_n),
	.avs_address(avs_address),
	.avs_read(avs_read),
	.avs_write(avs_write),
	.avs_writedata(avs_writedata),
	.avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest),
	.debug_mode(debug_mode),
	.count_clock_tick(count_clock_tick),
	.counter_at_max(counter_at_max),
	.counter_at_zero(counter_at_zero)
);
`default_nettype wire

// ### tcc_top_test.sv
// self-checking bench for the timer control core
`timescale 1ns/10ps
`default_nettype none
`include "tcc_cfg.svh"
module tcc_top_test;
	localparam logic [4:0] A_CLK = `TCC_OFS_CLK;
	localparam logic [4:0] A_CTL = `TCC_OFS_CTL;
	localparam logic [4:0] A_MAX = `TCC_OFS_MAX;
	localparam logic [4:0] A_CNT = `TCC_OFS_CNT;
	localparam logic [4:0] A_STS = `TCC_OFS_STS;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [4:0] adr = 5'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdat = 32'h00000000;
	logic [3:0] be = 4'hF;
	logic [31:0] rdat;
	logic wreq;
	logic [3:0] osc = 4'h0;
	logic osc_run = 1'b1;
	logic dbg = 1'b0;
	logic tick;
	logic at_max;
	logic at_zero;
	logic [15:0] v;
	logic [15:0] c;
	int tick_cnt = 0;
	int checked = 0;
	int fail_count = 0;
	// source 4 is absent on this build
	logic [15:0] clk_v [11] = '{16'h0010, 16'h0011, 16'h0012, 16'h0013,
		16'h0014, 16'h0015, 16'h0016, 16'h0017, 16'h00F1, 16'h00F0, 16'h0081};
	logic [15:0] rb_v [11] = '{16'h0010, 16'h0011, 16'h0012, 16'h0013,
		16'h0013, 16'h0015, 16'h0016, 16'h0017, 16'h00F1, 16'h00F0, 16'h0081};
	int exp_v [11] = '{32, 16, 8, 64, 64, 16, 32, 16, 32, 0, 0};
	always #25 clk = ~clk;
	// oscillators of periods 4, 8 and 16 cycles; freeze to stop source edges
	always @(posedge clk) begin
		if (osc_run)
			osc <= osc + 4'h1;
		if (tick === 1'b1)
			tick_cnt <= tick_cnt + 1;
	end
	tcc_top #(.SRC_PRESENT(8'hEF)) dut (
		.clk(clk), .rst_n(rst_n), .avs_address(adr), .avs_read(rd),
		.avs_write(wr), .avs_writedata(wdat), .avs_byteenable(be),
		.avs_readdata(rdat), .avs_waitrequest(wreq),
		.internal_rc_osc(osc[1]), .low_speed_osc(osc[2]),
		.high_speed_osc(osc[3]), .external_osc_input(osc[1]),
		.ext_clock_pin_0(osc[2]), .ext_clock_pin_1(osc[3]),
		.debug_mode(dbg), .count_clock_tick(tick),
		.counter_at_max(at_max), .counter_at_zero(at_zero)
	);
	task automatic summarize;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : summarize
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		checked++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", nm, e, g);
			fail_count++;
		end
	endtask : chk
	task automatic rng(input string nm, input int lo, input int hi,
		input int g);
		checked++;
		if (g < lo || g > hi) begin
			$display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, g);
			fail_count++;
		end
	endtask : rng
	task automatic bus(input logic w, input logic [4:0] a,
		input logic [15:0] d, output logic [15:0] q);
		int n;
		n = 0;
		@(posedge clk);
		adr <= a;
		rd <= ~w;
		wr <= w;
		wdat <= {16'h0000, d};
		// hold the request until a rising edge samples waitrequest low
		do begin
			@(posedge clk);
			n++;
			if (n > 20) begin
				$display("ERROR waitrequest expected 0 seen %b", wreq);
				fail_count++;
				summarize();
			end
		end while (wreq !== 1'b0);
		q = rdat[15:0];
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus
	task automatic wreg(input logic [4:0] a, input logic [15:0] d);
		logic [15:0] q;
		bus(1'b1, a, d, q);
	endtask : wreg
	task automatic rchk(input string nm, input logic [4:0] a,
		input logic [15:0] e);
		bus(1'b0, a, 16'h0000, v);
		chk(nm, e, v);
	endtask : rchk
	task automatic wait_ev(input bit zero);
		int n;
		n = 0;
		@(negedge clk);
		while ((zero ? at_zero : at_max) !== 1'b1) begin
			n++;
			if (n > 2000) begin
				$display("ERROR count event expected 1 seen 0");
				fail_count++;
				summarize();
			end
			@(negedge clk);
		end
	endtask : wait_ev
	task automatic window(input string nm, input int lo, input int hi);
		repeat (8) @(negedge clk);
		tick_cnt = 0;
		repeat (40) @(negedge clk);
		rng(nm, lo, hi, tick_cnt);
	endtask : window
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		rchk("clock ctl", A_CLK, 16'h0000);
		rchk("counter ctl", A_CTL, 16'h0000);
		rchk("max value", A_MAX, 16'hFFFF);
		rchk("count value", A_CNT, 16'h0000);
		rchk("status", A_STS, 16'h0002);
		rchk("unmapped", 5'h14, 16'h0000);
		wreg(A_CLK, 16'hFFFF);
		rchk("clock ctl", A_CLK, 16'h01F7);
		wreg(A_CLK, 16'h0000);
		wreg(A_CTL, 16'hFEF0);
		rchk("counter ctl", A_CTL, 16'h0000);
		wreg(A_CTL, 16'h0006);
		rchk("counter ctl", A_CTL, 16'h0000);
		rchk("status", A_STS, 16'h0002);
		@(posedge clk) osc_run <= 1'b0;
		wreg(A_CTL, 16'h0001);
		wreg(A_MAX, 16'h0005);
		rchk("counter ctl", A_CTL, 16'h0101);
		wreg(A_MAX, 16'h0009);
		rchk("max value", A_MAX, 16'h0005);
		@(posedge clk) osc_run <= 1'b1;
		repeat (40) @(posedge clk);
		rchk("counter ctl", A_CTL, 16'h0001);
		wreg(A_CTL, 16'h0007);
		wait_ev(1'b0);
		tick_cnt = 0;
		wait_ev(1'b0);
		rng("ticks per cycle", 6, 6, tick_cnt);
		rchk("status", A_STS, 16'h0003);
		wreg(A_CTL, 16'h0001);
		bus(1'b0, A_CNT, 16'h0000, c);
		repeat (20) @(posedge clk);
		rchk("count value", A_CNT, c);
		rchk("status", A_STS, 16'h0002);
		wreg(A_CTL, 16'h0003);
		rchk("count value", A_CNT, 16'h0000);
		rchk("counter ctl", A_CTL, 16'h0001);
		wreg(A_CTL, 16'h0013);
		rchk("count value", A_CNT, 16'h0005);
		rchk("status", A_STS, 16'h0000);
		wreg(A_CTL, 16'h001D);
		wait_ev(1'b1);
		repeat (4) @(posedge clk);
		rchk("counter ctl", A_CTL, 16'h0019);
		rchk("count value", A_CNT, 16'h0000);
		wreg(A_CTL, 16'h000B);
		wreg(A_CTL, 16'h000D);
		wait_ev(1'b0);
		repeat (4) @(posedge clk);
		rchk("counter ctl", A_CTL, 16'h0009);
		rchk("count value", A_CNT, 16'h0005);
		wreg(A_CTL, 16'h0027);
		wait_ev(1'b0);
		wait_ev(1'b1);
		wait_ev(1'b0);
		rchk("counter ctl", A_CTL, 16'h0025);
		wreg(A_CTL, 16'h0001);
		@(posedge clk) dbg <= 1'b1;
		window("debug ticks", 0, 0);
		wreg(A_CLK, 16'h0100);
		window("debug ticks", 9, 11);
		@(posedge clk) dbg <= 1'b0;
		wreg(A_CTL, 16'h0000);
		window("disabled ticks", 0, 0);
		wreg(A_CTL, 16'h0001);
		for (int i = 0; i < 11; i++) begin
			wreg(A_CLK, clk_v[i]);
			rchk("clock ctl", A_CLK, rb_v[i]);
			repeat (16) @(negedge clk);
			tick_cnt = 0;
			repeat (256) @(negedge clk);
			rng("source ticks", (exp_v[i] > 0) ? exp_v[i] - 1 : 0,
				exp_v[i] + 1, tick_cnt);
		end
		@(posedge clk) rst_n <= 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rchk("max value", A_MAX, 16'hFFFF);
		summarize();
	end
endmodule : tcc_top_test
`default_nettype wire
